// [common/ssd_pkg.sv]
/*
 * Shared constants and types for the subtract, nibble-exchange and
 * skip-on-zero datapath slice.
 * Assumes an 8-bit data path and a decoder that presents one operation
 * at a time with a one-cycle start pulse.
 */
package ssd_pkg;

    localparam int DW = 8;
    localparam int NW = 4;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;

    // Operation codes presented by the instruction decoder.
    typedef enum logic [2:0] {
        SSD_OP_NONE = 3'h0,
        SSD_OP_SUB_MEM = 3'h1,
        SSD_OP_SUB_IMM = 3'h2,
        SSD_OP_SWAP_MEM = 3'h3,
        SSD_OP_SWAP_ACC = 3'h4,
        SSD_OP_SKIP_ZERO = 3'h5,
        SSD_OP_SKIP_ZERO_MOVE = 3'h6
    } ssd_op_t;

    // Sequencer states, Gray coded along idle -> exec -> dummy.
    typedef enum logic [1:0] {
        SSD_ST_IDLE = 2'h0,
        SSD_ST_EXEC = 2'h1,
        SSD_ST_DUMMY = 2'h3
    } ssd_state_t;

    typedef struct packed {
        logic [7:0] diff;
        logic carry;
        logic ovf;
        logic zero;
        logic half;
    } ssd_sub_res_t;

endpackage : ssd_pkg

// [common/ssd_alu_if.sv]
/*
 * Carrier between the sequencer and the subtract unit.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface ssd_alu_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    ssd_pkg::ssd_sub_res_t res;

    modport ctl (output minuend, output subtrahend, input res);
    modport alu (input minuend, input subtrahend, output res);
endinterface : ssd_alu_if

// [hdl/ssd_sub_unit.sv]
/*
 * Combinational 8-bit subtractor with carry, overflow, zero and
 * half-carry results.
 * Assumes operands are stable for the cycle in which the result is used.
 */
`timescale 1ns/1ps
module ssd_sub_unit (
    ssd_alu_if.alu port_a
);
    logic [ssd_pkg::DW:0] full;
    logic [ssd_pkg::NW:0] low;

    // ------------------------------------------------------------------
    // Difference and flags
    // ------------------------------------------------------------------
    always_comb begin
        full = {1'b0, port_a.minuend} - {1'b0, port_a.subtrahend};
        low = {1'b0, port_a.minuend[ssd_pkg::NW-1:0]}
              - {1'b0, port_a.subtrahend[ssd_pkg::NW-1:0]};
        port_a.res.diff = full[ssd_pkg::DW-1:0];
        // Carry is the inverted borrow: one when no borrow occurred.
        port_a.res.carry = ~full[ssd_pkg::DW];
        port_a.res.half = ~low[ssd_pkg::NW];
        port_a.res.zero = (full[ssd_pkg::DW-1:0]
                           == ssd_pkg::ZERO_BYTE);
        port_a.res.ovf = (port_a.minuend[ssd_pkg::SIGN_BIT]
                          ^ port_a.subtrahend[ssd_pkg::SIGN_BIT])
                         & (port_a.minuend[ssd_pkg::SIGN_BIT]
                          ^ full[ssd_pkg::SIGN_BIT]);
    end

endmodule : ssd_sub_unit

// [hdl/ssd_datapath.sv]
/*
 * Datapath slice for subtract, nibble exchange and skip-on-zero.
 * Assumes the decoder pulses op_start with op, the memory byte and the
 * immediate valid in that cycle, and holds off new operations while busy.
 */
// Functional notes
// - Subtract-to-memory writes accumulator minus memory byte to memory.
// - Subtraction carry is 0 on negative result, 1 otherwise.
// - Subtract-immediate subtracts instruction constant from accumulator.
// - Subtract-immediate writes accumulator only, never memory.
// - In-place swap exchanges nibbles of the memory byte.
// - Swap-to-accumulator loads nibble-exchanged memory byte into accumulator.
// - Swap-to-accumulator leaves the memory byte untouched.
// - Skip-on-zero reads the memory byte and writes it back unchanged.
// - Zero tested byte skips the next sequential instruction.
// - Skip-on-zero stays busy two cycles only when it skips, the second a dummy.
// - Nonzero tested byte continues without any skip.
// - Skip-with-move copies byte to accumulator and skips on zero.
`timescale 1ns/1ps
module ssd_datapath (
    input wire logic clock,
    input wire logic nrst,
    input wire logic op_start,
    input wire ssd_pkg::ssd_op_t op,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] imm_data,
    output logic busy,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic [7:0] accumulator,
    output logic carry_flag,
    output logic overflow_flag,
    output logic zero_flag,
    output logic half_carry_flag,
    output logic skip_next,
    output logic dummy_cycle
);

    typedef struct packed {
        ssd_pkg::ssd_state_t st;
        logic [7:0] acc;
        logic c;
        logic ovf;
        logic z;
        logic hc;
        logic we;
        logic [7:0] wdata;
        logic skip;
        logic dummy;
    } ssd_regs_t;

    ssd_regs_t s_r;
    ssd_regs_t s_nxt;
    ssd_alu_if alu_if ();

    function automatic logic [7:0] nib_swap(input logic [7:0] b);
        nib_swap = {b[ssd_pkg::NW-1:0], b[ssd_pkg::DW-1:ssd_pkg::NW]};
    endfunction : nib_swap

    function automatic logic is_skip(input ssd_pkg::ssd_op_t o);
        is_skip = (o == ssd_pkg::SSD_OP_SKIP_ZERO)
                  || (o == ssd_pkg::SSD_OP_SKIP_ZERO_MOVE);
    endfunction : is_skip

    ssd_sub_unit u_sub (
        .port_a(alu_if.alu)
    );

    // Operands are driven outside the next-state process so that the
    // subtractor result read back there forms no apparent loop.
    assign alu_if.minuend = s_r.acc;
    assign alu_if.subtrahend = (op == ssd_pkg::SSD_OP_SUB_IMM)
                               ? imm_data : mem_rdata;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.skip = 1'b0;
        s_nxt.dummy = 1'b0;
        unique case (s_r.st)
            ssd_pkg::SSD_ST_IDLE: begin
                if (op_start) begin
                    unique case (op)
                        ssd_pkg::SSD_OP_SUB_MEM: begin
                            s_nxt.we = 1'b1;
                            s_nxt.wdata = alu_if.res.diff;
                        end
                        ssd_pkg::SSD_OP_SUB_IMM: begin
                            s_nxt.acc = alu_if.res.diff;
                        end
                        ssd_pkg::SSD_OP_SWAP_MEM: begin
                            s_nxt.we = 1'b1;
                            s_nxt.wdata = nib_swap(mem_rdata);
                        end
                        ssd_pkg::SSD_OP_SWAP_ACC: begin
                            s_nxt.acc = nib_swap(mem_rdata);
                        end
                        ssd_pkg::SSD_OP_SKIP_ZERO: begin
                            s_nxt.we = 1'b1;
                            s_nxt.wdata = mem_rdata;
                        end
                        ssd_pkg::SSD_OP_SKIP_ZERO_MOVE: begin
                            s_nxt.acc = mem_rdata;
                        end
                        default: begin
                        end
                    endcase
                    // Only subtractions touch the flags.
                    if (op == ssd_pkg::SSD_OP_SUB_MEM
                        || op == ssd_pkg::SSD_OP_SUB_IMM) begin
                        s_nxt.c = alu_if.res.carry;
                        s_nxt.ovf = alu_if.res.ovf;
                        s_nxt.z = alu_if.res.zero;
                        s_nxt.hc = alu_if.res.half;
                    end
                    // Skip only on a zero byte; otherwise run on.
                    if (is_skip(op) && mem_rdata == ssd_pkg::ZERO_BYTE) begin
                        s_nxt.skip = 1'b1;
                        s_nxt.st = ssd_pkg::SSD_ST_EXEC;
                    end
                end
            end
            ssd_pkg::SSD_ST_EXEC: begin
                // Second cycle: the skipped word is replaced by a dummy.
                s_nxt.dummy = 1'b1;
                s_nxt.st = ssd_pkg::SSD_ST_DUMMY;
            end
            ssd_pkg::SSD_ST_DUMMY: begin
                s_nxt.st = ssd_pkg::SSD_ST_IDLE;
            end
            default: begin
                s_nxt.st = ssd_pkg::SSD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{st: ssd_pkg::SSD_ST_IDLE, acc: ssd_pkg::ACC_RST,
                     c: 1'b0, ovf: 1'b0, z: 1'b0, hc: 1'b0, we: 1'b0,
                     wdata: ssd_pkg::ZERO_BYTE, skip: 1'b0, dummy: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.st != ssd_pkg::SSD_ST_IDLE);
    assign mem_we = s_r.we;
    assign mem_wdata = s_r.wdata;
    assign accumulator = s_r.acc;
    assign carry_flag = s_r.c;
    assign overflow_flag = s_r.ovf;
    assign zero_flag = s_r.z;
    assign half_carry_flag = s_r.hc;
    assign skip_next = s_r.skip;
    assign dummy_cycle = s_r.dummy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_skip_go;
        op_start && !busy && is_skip(op) && mem_rdata == ssd_pkg::ZERO_BYTE;
    endsequence

    sequence s_two_cycle;
        skip_next ##1 dummy_cycle ##1 !busy;
    endsequence

    property p_sub_mem;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SUB_MEM |=>
        mem_we && mem_wdata == $past(accumulator) - $past(mem_rdata);
    endproperty
    a_sub_mem: assert property (p_sub_mem)
        else $error("sub to memory wrote wrong value");

    property p_carry;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && (op == ssd_pkg::SSD_OP_SUB_MEM
            || op == ssd_pkg::SSD_OP_SUB_IMM) |=>
        carry_flag == ($past(accumulator)
            >= ($past(op) == ssd_pkg::SSD_OP_SUB_IMM
                ? $past(imm_data) : $past(mem_rdata)));
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry flag wrong after subtract");

    property p_sub_imm;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SUB_IMM |=>
        accumulator == $past(accumulator) - $past(imm_data) && !mem_we;
    endproperty
    a_sub_imm: assert property (p_sub_imm)
        else $error("subtract immediate result wrong");

    property p_zero;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && (op == ssd_pkg::SSD_OP_SUB_MEM
            || op == ssd_pkg::SSD_OP_SUB_IMM) |=>
        zero_flag == ($past(accumulator)
            == ($past(op) == ssd_pkg::SSD_OP_SUB_IMM
                ? $past(imm_data) : $past(mem_rdata)));
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong after subtract");

    property p_swap_acc;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SWAP_ACC |=>
        accumulator[3:0] == $past(mem_rdata[7:4])
        && accumulator[7:4] == $past(mem_rdata[3:0]) && !mem_we;
    endproperty
    a_swap_acc: assert property (p_swap_acc)
        else $error("swap to accumulator wrong");

    property p_skip;
        @(posedge clock) disable iff (!nrst)
        s_skip_go |=> s_two_cycle;
    endproperty
    a_skip: assert property (p_skip)
        else $error("zero skip sequence wrong");

    property p_no_skip;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && is_skip(op) && mem_rdata != ssd_pkg::ZERO_BYTE
        |=> !skip_next && !busy;
    endproperty
    a_no_skip: assert property (p_no_skip)
        else $error("skip taken on nonzero byte");

    property p_flags_kept;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && (is_skip(op) || op == ssd_pkg::SSD_OP_SWAP_MEM
            || op == ssd_pkg::SSD_OP_SWAP_ACC) |=>
        $stable(carry_flag) && $stable(overflow_flag)
        && $stable(zero_flag) && $stable(half_carry_flag);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("flags changed on swap or skip");

    property p_swap_mem;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SWAP_MEM |=>
        mem_we && mem_wdata[7:4] == $past(mem_rdata[3:0])
        && mem_wdata[3:0] == $past(mem_rdata[7:4]) && $stable(accumulator);
    endproperty
    a_swap_mem: assert property (p_swap_mem)
        else $error("in-place nibble exchange wrong");

    property p_skip_write;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SKIP_ZERO |=>
        mem_we && mem_wdata == $past(mem_rdata) && $stable(accumulator);
    endproperty
    a_skip_write: assert property (p_skip_write)
        else $error("skip on zero did not write the byte back");

    property p_skip_move;
        @(posedge clock) disable iff (!nrst)
        op_start && !busy && op == ssd_pkg::SSD_OP_SKIP_ZERO_MOVE |=>
        accumulator == $past(mem_rdata) && !mem_we;
    endproperty
    a_skip_move: assert property (p_skip_move)
        else $error("skip with move did not load the accumulator");

endmodule : ssd_datapath

// [verif/ssd_mem_model.sv]
/*
 * Single data memory byte standing in for the addressed location.
 * Assumes the bench presets the byte through set_en between operations.
 */
`timescale 1ns/1ps
module ssd_mem_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic set_en,
    input wire logic [7:0] set_val,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem_r;

    assign mem_rdata = mem_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mem_r <= 8'h00;
        end else if (set_en) begin
            mem_r <= set_val;
        end else if (mem_we) begin
            mem_r <= mem_wdata;
        end
    end
endmodule : ssd_mem_model

// [verif/subtract_swap_skip_datapath_tb.sv]
/*
 * Self-checking bench for the subtract, nibble-exchange and skip datapath.
 * Assumes the memory model answers mem_rdata from its stored byte.
 */
`timescale 1ns/1ps
module subtract_swap_skip_datapath_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic op_start = 1'b0;
    logic set_en = 1'b0;
    ssd_pkg::ssd_op_t op = ssd_pkg::SSD_OP_NONE;
    logic [7:0] imm_data = 8'h00;
    logic [7:0] set_val = 8'h00;
    logic [7:0] mem_rdata, mem_wdata, accumulator;
    logic busy, mem_we, skip_next, dummy_cycle;
    logic carry_flag, overflow_flag, zero_flag, half_carry_flag;
    logic [3:0] fg;
    int fail_count = 0;
    int tests_run = 0;

    assign fg = {carry_flag, overflow_flag, zero_flag, half_carry_flag};
    always #5 clock = ~clock;

    ssd_datapath u_dut (.clock(clock), .nrst(nrst), .op_start(op_start),
        .op(op), .mem_rdata(mem_rdata), .imm_data(imm_data), .busy(busy),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .accumulator(accumulator),
        .carry_flag(carry_flag), .overflow_flag(overflow_flag),
        .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
        .skip_next(skip_next), .dummy_cycle(dummy_cycle));
    ssd_mem_model u_mem (.clock(clock), .nrst(nrst), .set_en(set_en),
        .set_val(set_val), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Expected {carry, overflow, zero, half carry} of a minus b.
    function automatic logic [3:0] fl(input logic [7:0] a,
                                      input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {a >= b, (a[7] != b[7]) && (d[7] != a[7]), d == 8'h00,
                a[3:0] >= b[3:0]};
    endfunction : fl

    task automatic go(input ssd_pkg::ssd_op_t o, input logic [7:0] im);
        @(posedge clock);
        op_start <= 1'b1;
        op <= o;
        imm_data <= im;
        @(posedge clock);
        op_start <= 1'b0;
        op <= ssd_pkg::SSD_OP_NONE;
        #1;
    endtask : go

    task automatic set_mem(input logic [7:0] v);
        @(posedge clock);
        set_en <= 1'b1;
        set_val <= v;
        @(posedge clock);
        set_en <= 1'b0;
        #1;
    endtask : set_mem

    task automatic t_skip(input logic [7:0] m, input logic mv);
        logic [3:0] f;
        logic [7:0] a;
        set_mem(m);
        f = fg;
        a = mv ? m : accumulator;
        go(mv ? ssd_pkg::SSD_OP_SKIP_ZERO_MOVE : ssd_pkg::SSD_OP_SKIP_ZERO,
           8'h00);
        chk("skip_next", 8'(m == 8'h00), 8'(skip_next));
        chk("busy", 8'(m == 8'h00), 8'(busy));
        chk("mem_we", 8'(!mv), 8'(mem_we));
        if (!mv) chk("mem_wdata", m, mem_wdata);
        chk("acc", a, accumulator);
        chk("flags", 8'(f), 8'(fg));
        if (m == 8'h00) begin
            @(posedge clock);
            op_start <= 1'b1;
            op <= ssd_pkg::SSD_OP_SUB_IMM;
            imm_data <= 8'h01;
            #1 chk("dummy", 8'h01, 8'(dummy_cycle));
            chk("busy2", 8'h01, 8'(busy));
            @(posedge clock);
            op_start <= 1'b0;
            op <= ssd_pkg::SSD_OP_NONE;
            #1 chk("busy3", 8'h00, 8'(busy));
            chk("acc_refused", a, accumulator);
        end
    endtask : t_skip

    task automatic t_sub_imm(input logic [7:0] a, input logic [7:0] x);
        t_skip(a, 1'b1);
        go(ssd_pkg::SSD_OP_SUB_IMM, x);
        chk("acc", a - x, accumulator);
        chk("mem_we", 8'h00, 8'(mem_we));
        chk("flags", 8'(fl(a, x)), 8'(fg));
        chk("mem", a, mem_rdata);
    endtask : t_sub_imm

    task automatic t_sub_mem(input logic [7:0] a, input logic [7:0] m);
        t_skip(a, 1'b1);
        set_mem(m);
        go(ssd_pkg::SSD_OP_SUB_MEM, 8'h00);
        chk("mem_we", 8'h01, 8'(mem_we));
        chk("mem_wdata", a - m, mem_wdata);
        chk("acc", a, accumulator);
        chk("flags", 8'(fl(a, m)), 8'(fg));
    endtask : t_sub_mem

    task automatic t_swap(input logic [7:0] m, input logic ta);
        logic [3:0] f;
        logic [7:0] a;
        set_mem(m);
        f = fg;
        a = accumulator;
        go(ta ? ssd_pkg::SSD_OP_SWAP_ACC : ssd_pkg::SSD_OP_SWAP_MEM, 8'h00);
        chk("acc", ta ? {m[3:0], m[7:4]} : a, accumulator);
        chk("mem_we", 8'(!ta), 8'(mem_we));
        chk("flags", 8'(f), 8'(fg));
        @(posedge clock);
        #1 chk("mem", ta ? m : {m[3:0], m[7:4]}, mem_rdata);
    endtask : t_swap

    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        #1 chk("acc_rst", 8'h00, accumulator);
        chk("flags_rst", 8'h00, 8'({fg, busy}));
        t_sub_imm(8'h10, 8'h20);
        t_sub_imm(8'h55, 8'h55);
        t_sub_imm(8'h80, 8'h01);
        t_sub_imm(8'h13, 8'h04);
        t_sub_mem(8'h05, 8'h07);
        t_sub_mem(8'h7f, 8'hff);
        t_swap(8'ha5, 1'b0);
        t_swap(8'h1e, 1'b1);
        t_skip(8'h00, 1'b0);
        t_skip(8'h40, 1'b0);
        t_skip(8'h00, 1'b1);
        wrap_up();
    end

    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule : subtract_swap_skip_datapath_tb
